// ### pkg/sfh_consts.svh
`ifndef SFH_CONSTS_SVH
`define SFH_CONSTS_SVH

// Timing
`define SFH_CLK_NS          50
`define SFH_SCLK_PERIOD_NS  400
`define SFH_HALF_CYC        (`SFH_SCLK_PERIOD_NS / 2 / `SFH_CLK_NS)

// Control byte layout
`define SFH_CTRL_SOCK_HI    7
`define SFH_CTRL_SOCK_LO    5
`define SFH_CTRL_SUB_HI     4
`define SFH_CTRL_SUB_LO     3
`define SFH_CTRL_DIR        2
`define SFH_CTRL_MODE_HI    1
`define SFH_CTRL_MODE_LO    0

// Field codes
`define SFH_DIR_READ        1'h0
`define SFH_DIR_WRITE       1'h1
`define SFH_MODE_VAR        2'h0
`define SFH_MODE_FIX1       2'h1
`define SFH_MODE_FIX2       2'h2
`define SFH_MODE_FIX4       2'h3
`define SFH_LEN_FIX1        3'h1
`define SFH_LEN_FIX2        3'h2
`define SFH_LEN_FIX4        3'h4
`define SFH_SUB_COMMON      2'h0
`define SFH_SOCK_ZERO       3'h0
`define SFH_STRAP_SPI       3'h0

// Framing
`define SFH_LAST_BIT        3'h7
`define SFH_HDR_BITS        6'h18
`define SFH_FRAME_BITS      56
`define SFH_RD_BITS         32

`endif

// ### pkg/sfh_pkg.sv
package sfh_pkg;
	typedef enum logic [1:0] {ph_addr, ph_ctrl, ph_data} sfh_phase_t;
	typedef enum logic [2:0] {hs_idle, hs_lead, hs_high, hs_low, hs_tail, hs_gap} sfh_host_state_t;
	typedef logic [2:0]  sfh_socket_t;
	typedef logic [15:0] sfh_addr_t;
endpackage

// ### pkg/sfh_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sfh_link_if;
	logic sclk;
	logic chip_select_low;
	logic mosi;
	logic miso;
	logic miso_oe;

	modport dev (
		input  sclk,
		input  chip_select_low,
		input  mosi,
		output miso,
		output miso_oe
	);

	modport host (
		output sclk,
		output chip_select_low,
		output mosi,
		input  miso,
		input  miso_oe
	);
endinterface
`default_nettype wire

// ### hdl/sfh_dev.sv
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sfh_consts.svh"

// Function
// - Modes 0/3: sample rising, change falling
// - Bytes shifted MSB first, one per clock
// - Frame order: address, control, data
// - Sixteen-bit offset address, high byte first
// - Offset increments after every data byte
// - Control bits 7:3 select socket and sub-block
// - Sub-block decode; code 00 common only socket 0
// - Control bit 2: 0 read, 1 write
// - Mode bits: 00 variable, else 1/2/4 bytes
// - Variable frame bounded by chip select edges
// - Variable data phase lasts while select low
// - Master frames select, sends mode 00
// - Fixed operation: chip select held low
// - Fixed operation never uses mode 00
// - Fixed: exact byte count, then new frame
// - Master data length matches mode bits
// - Master changes output bits on falling edge
// - Device shifts read bits on falling edge
// - Slave active only for strap 000X
module sfh_dev (
	input  wire logic             clk,
	input  wire logic             rst,
	sfh_link_if.dev               link,
	input  wire logic [3:0]       host_if_strap,
	output logic                  acc_req,
	output logic                  acc_write,
	output sfh_pkg::sfh_socket_t  acc_socket,
	output logic [1:0]            acc_sub,
	output sfh_pkg::sfh_addr_t    acc_addr,
	output logic [7:0]            acc_wdata,
	input  wire logic [7:0]       acc_rdata,
	output logic                  spi_enabled,
	output logic                  frame_active
);
	import sfh_pkg::*;

	logic       sclk_s1, sclk_s2, sclk_s3;
	logic       cs_s1, cs_s2;
	logic       mosi_s1, mosi_s2;
	logic [3:0] strap_s1, strap_s2;
	logic       sclk_rise, sclk_fall, sel;

	sfh_phase_t phase;
	logic [2:0] bit_cnt;
	logic [2:0] byte_cnt;
	logic [6:0] rx;
	logic [7:0] ctrl;
	sfh_addr_t  addr;
	logic [7:0] byte_in;
	logic       byte_done;
	logic [7:0] cur_ctrl;
	logic [2:0] fix_len;
	logic       last_fixed;
	logic       reserved;
	logic       rd_load, rd_zero, rd_take;
	logic [7:0] rd_hold;
	logic [7:0] tx;

	// Pins from the master's domain pass two flops first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_s1  <= 1'h0;
			sclk_s2  <= 1'h0;
			sclk_s3  <= 1'h0;
			cs_s1    <= 1'h1;
			cs_s2    <= 1'h1;
			mosi_s1  <= 1'h0;
			mosi_s2  <= 1'h0;
			strap_s1 <= 4'hF;
			strap_s2 <= 4'hF;
		end else begin
			sclk_s1  <= link.sclk;
			sclk_s2  <= sclk_s1;
			sclk_s3  <= sclk_s2;
			cs_s1    <= link.chip_select_low;
			cs_s2    <= cs_s1;
			mosi_s1  <= link.mosi;
			mosi_s2  <= mosi_s1;
			strap_s1 <= host_if_strap;
			strap_s2 <= strap_s1;
		end
	end

	// Strap is followed every cycle after reset release, never under it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			spi_enabled <= 1'h0;
		end else begin
			spi_enabled <= (strap_s2[3:1] == `SFH_STRAP_SPI);
		end
	end

	assign sclk_rise = sclk_s2 & ~sclk_s3;
	assign sclk_fall = ~sclk_s2 & sclk_s3;
	// Fixed operation has select tied low, so it is selected whenever spi_enabled is set
	assign sel = spi_enabled & ~cs_s2;
	assign frame_active = sel;

	assign byte_in   = {rx, mosi_s2};
	assign byte_done = sel & sclk_rise & (bit_cnt == `SFH_LAST_BIT);
	assign cur_ctrl  = (phase == ph_ctrl) ? byte_in : ctrl;

	always_comb begin
		unique case (ctrl[`SFH_CTRL_MODE_HI:`SFH_CTRL_MODE_LO])
			`SFH_MODE_FIX1: fix_len = `SFH_LEN_FIX1;
			`SFH_MODE_FIX2: fix_len = `SFH_LEN_FIX2;
			`SFH_MODE_FIX4: fix_len = `SFH_LEN_FIX4;
			`SFH_MODE_VAR:  fix_len = 3'h0;
		endcase
	end

	// Last byte of a fixed frame; variable frames end only on select
	assign last_fixed = (ctrl[`SFH_CTRL_MODE_HI:`SFH_CTRL_MODE_LO] != `SFH_MODE_VAR)
		&& (byte_cnt + 3'h1 == fix_len);

	assign reserved = (cur_ctrl[`SFH_CTRL_SUB_HI:`SFH_CTRL_SUB_LO] == `SFH_SUB_COMMON)
		&& (cur_ctrl[`SFH_CTRL_SOCK_HI:`SFH_CTRL_SOCK_LO] != `SFH_SOCK_ZERO);

	// Phase tracking
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase    <= ph_addr;
			bit_cnt  <= 3'h0;
			byte_cnt <= 3'h0;
			rx       <= 7'h00;
			ctrl     <= 8'h00;
			addr     <= 16'h0000;
		end else if (!sel) begin
			// Deselect drops any partial byte
			phase    <= ph_addr;
			bit_cnt  <= 3'h0;
			byte_cnt <= 3'h0;
		end else if (sclk_rise) begin
			rx      <= byte_in[6:0];
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == `SFH_LAST_BIT) begin
				unique case (phase)
					ph_addr: begin
						if (byte_cnt == 3'h0) begin
							addr[15:8] <= byte_in;
							byte_cnt   <= 3'h1;
						end else begin
							addr[7:0] <= byte_in;
							byte_cnt  <= 3'h0;
							phase     <= ph_ctrl;
						end
					end
					ph_ctrl: begin
						ctrl  <= byte_in;
						phase <= ph_data;
					end
					ph_data: begin
						addr     <= addr + 16'h0001;
						byte_cnt <= byte_cnt + 3'h1;
						if (last_fixed) begin
							phase    <= ph_addr;
							byte_cnt <= 3'h0;
						end
					end
				endcase
			end
		end
	end

	// Access port toward the register file and buffers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_req    <= 1'h0;
			acc_write  <= 1'h0;
			acc_socket <= 3'h0;
			acc_sub    <= 2'h0;
			acc_addr   <= 16'h0000;
			acc_wdata  <= 8'h00;
			rd_load    <= 1'h0;
			rd_zero    <= 1'h0;
		end else begin
			acc_req <= 1'h0;
			rd_load <= 1'h0;
			if (byte_done && phase != ph_addr) begin
				acc_socket <= cur_ctrl[`SFH_CTRL_SOCK_HI:`SFH_CTRL_SOCK_LO];
				acc_sub    <= cur_ctrl[`SFH_CTRL_SUB_HI:`SFH_CTRL_SUB_LO];
				rd_zero    <= reserved;
				if (phase == ph_ctrl && byte_in[`SFH_CTRL_DIR] == `SFH_DIR_READ) begin
					// Fetch the first read byte before its first falling edge
					acc_req   <= ~reserved;
					acc_write <= 1'h0;
					acc_addr  <= addr;
					rd_load   <= 1'h1;
				end else if (phase == ph_data && ctrl[`SFH_CTRL_DIR] == `SFH_DIR_WRITE) begin
					acc_req   <= ~reserved;
					acc_write <= 1'h1;
					acc_addr  <= addr;
					acc_wdata <= byte_in;
				end else if (phase == ph_data && !last_fixed) begin
					// Prefetch the next location of a read
					acc_req   <= ~reserved;
					acc_write <= 1'h0;
					acc_addr  <= addr + 16'h0001;
					rd_load   <= 1'h1;
				end
			end
		end
	end

	// Read data arrives the cycle after the request, so capture one cycle late
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_take <= 1'h0;
			rd_hold <= 8'h00;
		end else begin
			rd_take <= rd_load;
			if (rd_take) begin
				rd_hold <= rd_zero ? 8'h00 : acc_rdata;
			end
		end
	end

	// Read shifter moves on the falling edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx <= 8'h00;
		end else if (sel && sclk_fall && phase == ph_data
			&& ctrl[`SFH_CTRL_DIR] == `SFH_DIR_READ) begin
			if (bit_cnt == 3'h0) begin
				tx <= rd_hold;
			end else begin
				tx <= {tx[6:0], 1'h0};
			end
		end
	end

	assign link.miso    = tx[7];
	assign link.miso_oe = sel;
endmodule
`default_nettype wire

// ### hdl/sfh_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfh_consts.svh"

module sfh_host (
	input  wire logic                  clk,
	input  wire logic                  rst,
	sfh_link_if.host                   link,
	input  wire logic                  fixed_wiring,
	input  wire logic                  cmd_valid,
	output logic                       cmd_ready,
	input  wire logic                  cmd_write,
	input  wire logic [4:0]            cmd_block,
	input  wire sfh_pkg::sfh_addr_t    cmd_addr,
	input  wire logic [1:0]            cmd_mode,
	input  wire logic [2:0]            cmd_len,
	input  wire logic [31:0]           cmd_wdata,
	output logic                       rsp_valid,
	output logic [31:0]                rsp_rdata
);
	import sfh_pkg::*;

	localparam logic [2:0] HALF_LAST = 3'(`SFH_HALF_CYC - 1);

	sfh_host_state_t             state;
	logic [2:0]                  cnt;
	logic                        tick;
	logic                        miso_s1, miso_s2;
	logic [`SFH_FRAME_BITS-1:0]  tx;
	logic [5:0]                  bits_left;
	logic [5:0]                  data_bits;
	logic [`SFH_RD_BITS-1:0]     rx;
	logic                        sclk_r, cs_r, mosi_r, rd_dir;
	logic [1:0]                  send_mode;
	logic [2:0]                  nbytes;

	// Fixed wiring forbids variable mode, so such a command waits
	assign send_mode = fixed_wiring ? cmd_mode : `SFH_MODE_VAR;
	assign cmd_ready = (state == hs_idle) && !(fixed_wiring && cmd_mode == `SFH_MODE_VAR);

	always_comb begin
		unique case (send_mode)
			`SFH_MODE_FIX1: nbytes = `SFH_LEN_FIX1;
			`SFH_MODE_FIX2: nbytes = `SFH_LEN_FIX2;
			`SFH_MODE_FIX4: nbytes = `SFH_LEN_FIX4;
			// Data word holds four bytes; longer requests would overrun the bit count
			`SFH_MODE_VAR:  nbytes = (cmd_len == 3'h0) ? 3'h1
				: (cmd_len > `SFH_LEN_FIX4) ? `SFH_LEN_FIX4 : cmd_len;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			miso_s1 <= 1'h0;
			miso_s2 <= 1'h0;
		end else begin
			miso_s1 <= link.miso;
			miso_s2 <= miso_s1;
		end
	end

	// Half-period divider for the serial clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 3'h0;
		end else if (state == hs_idle || tick) begin
			cnt <= 3'h0;
		end else begin
			cnt <= cnt + 3'h1;
		end
	end
	assign tick = (state != hs_idle) && (cnt == HALF_LAST);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state     <= hs_idle;
			sclk_r    <= 1'h0;
			cs_r      <= 1'h1;
			mosi_r    <= 1'h0;
			tx        <= '0;
			rx        <= '0;
			bits_left <= 6'h00;
			data_bits <= 6'h00;
			rd_dir    <= 1'h0;
			rsp_valid <= 1'h0;
			rsp_rdata <= '0;
		end else begin
			rsp_valid <= 1'h0;
			unique case (state)
				hs_idle: begin
					if (cmd_valid && cmd_ready) begin
						tx <= {cmd_addr, cmd_block, cmd_write, send_mode,
							cmd_wdata};
						mosi_r    <= cmd_addr[15];
						data_bits <= {nbytes, 3'h0};
						bits_left <= `SFH_HDR_BITS + {nbytes, 3'h0};
						rd_dir    <= (cmd_write == `SFH_DIR_READ);
						rx        <= '0;
						cs_r      <= 1'h0;
						state     <= hs_lead;
					end
				end
				hs_lead, hs_low: begin
					if (tick) begin
						sclk_r <= 1'h1;
						state  <= hs_high;
					end
				end
				hs_high: begin
					if (tick) begin
						// Late in the high half, past the slave's sync delay
						if (rd_dir && bits_left <= data_bits) begin
							rx <= {rx[`SFH_RD_BITS-2:0], miso_s2};
						end
						sclk_r    <= 1'h0;
						bits_left <= bits_left - 6'h01;
						if (bits_left == 6'h01) begin
							state <= hs_tail;
						end else begin
							tx     <= {tx[`SFH_FRAME_BITS-2:0], 1'h0};
							mosi_r <= tx[`SFH_FRAME_BITS-2];
							state  <= hs_low;
						end
					end
				end
				hs_tail: begin
					if (tick) begin
						cs_r      <= 1'h1;
						rsp_valid <= 1'h1;
						rsp_rdata <= rx;
						state     <= hs_gap;
					end
				end
				hs_gap: begin
					if (tick) begin
						state <= hs_idle;
					end
				end
			endcase
		end
	end

	// Fixed wiring keeps select low at all times
	assign link.chip_select_low = cs_r & ~fixed_wiring;
	assign link.sclk = sclk_r;
	assign link.mosi = mosi_r;
endmodule
`default_nettype wire

// ### tb/sfh_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sfh_link_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic chip_select_low,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	logic       cs_q;
	logic       sclk_q;
	logic [7:0] bits;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_q   <= 1'h1;
			sclk_q <= 1'h0;
		end else begin
			cs_q   <= chip_select_low;
			sclk_q <= sclk;
		end
	end

	// Rising sclk edges since select fell
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			bits <= 8'h00;
		else if (cs_q && !chip_select_low)
			bits <= 8'h00;
		else if (sclk && !sclk_q)
			bits <= bits + 8'h01;
	end

	sequence sclk_high_half;
		sclk [*4] ##1 !sclk;
	endsequence

	sequence sclk_low_half;
		!sclk [*4];
	endsequence

	a_sclk_high_time: assert property ($rose(sclk) |-> sclk_high_half)
		else $error("sclk high phase wrong length");
	a_sclk_low_time: assert property ($fell(sclk) |-> sclk_low_half)
		else $error("sclk low phase too short");
	a_select_lead: assert property ($fell(chip_select_low) |-> sclk_low_half)
		else $error("sclk rose too soon after select");
	a_sclk_in_frame: assert property (sclk |-> !chip_select_low)
		else $error("sclk high while deselected");
	a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("mosi moved while sclk high");
	a_miso_steady: assert property (
		miso_oe && sclk && $past(sclk) |-> $stable(miso))
		else $error("miso moved while sclk high");
	a_oe_release: assert property ($rose(chip_select_low) |-> ##[1:4] !miso_oe)
		else $error("miso still driven after deselect");
	a_frame_whole: assert property (
		$rose(chip_select_low) |-> (bits >= 8'h20 && bits[2:0] == 3'h0))
		else $error("frame not whole bytes after header");
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sfh_pkg::*;
	logic        clk, rst, fixed_wiring, cmd_valid, cmd_ready, cmd_write, rsp_valid;
	logic        acc_req, acc_write, spi_enabled, frame_active;
	logic [4:0]  cmd_block;
	logic [1:0]  cmd_mode, acc_sub;
	logic [2:0]  cmd_len;
	logic [31:0] cmd_wdata, rsp_rdata;
	logic [3:0]  strap;
	logic [7:0]  acc_wdata, acc_rdata;
	sfh_addr_t   cmd_addr, acc_addr;
	sfh_socket_t acc_socket;
	int          miscompares, num_checks, exp_n;
	logic [28:0] wlog[$];
	logic [4:0]  blks[6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h1C};

	sfh_link_if link();

	sfh_host sfh_host_inst (.clk(clk), .rst(rst), .link(link), .fixed_wiring(fixed_wiring),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
		.cmd_block(cmd_block), .cmd_addr(cmd_addr), .cmd_mode(cmd_mode), .cmd_len(cmd_len),
		.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

	sfh_dev sfh_dev_inst (.clk(clk), .rst(rst), .link(link), .host_if_strap(strap),
		.acc_req(acc_req), .acc_write(acc_write), .acc_socket(acc_socket),
		.acc_sub(acc_sub), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
		.acc_rdata(acc_rdata), .spi_enabled(spi_enabled), .frame_active(frame_active));

	sfh_link_properties sfh_link_properties_inst (.clk(clk), .rst(rst), .sclk(link.sclk),
		.chip_select_low(link.chip_select_low), .mosi(link.mosi), .miso(link.miso),
		.miso_oe(link.miso_oe));

	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	// Memory stand-in: data known from the offset alone
	always @(posedge clk) begin
		if (rst === 1'h1) begin
			acc_rdata <= 8'h00;
		end else if (acc_req === 1'h1) begin
			acc_rdata <= acc_addr[7:0] ^ 8'hA5;
		end
		if (acc_req === 1'h1 && acc_write === 1'h1) begin
			wlog.push_back({acc_socket, acc_sub, acc_addr, acc_wdata});
		end
	end

	function automatic logic [31:0] rd_exp(input logic [15:0] a, input int n);
		logic [31:0] r;
		logic [15:0] ak;
		r = 32'h0;
		for (int k = 0; k < n; k++) begin
			ak = a + 16'(k);
			r = {r[23:0], ak[7:0] ^ 8'hA5};
		end
		return r;
	endfunction

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", what, e, s);
			miscompares++;
		end
	endtask

	task automatic test_done;
		if (miscompares == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic wait_for(input bit rsp, input int lim);
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while ((rsp ? rsp_valid : cmd_ready) !== 1'h1 && i < lim);
		if ((rsp ? rsp_valid : cmd_ready) !== 1'h1) begin
			chk(rsp ? "rsp_valid wait" : "cmd_ready wait", 32'h1, 32'h0);
			test_done;
		end
	endtask

	task automatic do_reset(input logic [3:0] s, input logic fw);
		strap <= s;
		fixed_wiring <= fw;
		rst <= 1'h1;
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		repeat (8) @(posedge clk);
	endtask

	task automatic xfer(input logic w, input logic [4:0] b, input logic [15:0] a,
		input logic [1:0] m, input logic [2:0] n, input logic [31:0] d);
		wlog.delete();
		cmd_valid <= 1'h1;
		cmd_write <= w;
		cmd_block <= b;
		cmd_addr <= a;
		cmd_mode <= m;
		cmd_len <= n;
		cmd_wdata <= d;
		wait_for(1'h0, 20);
		cmd_valid <= 1'h0;
		wait_for(1'h1, 1000);
	endtask

	task automatic chk_writes(input logic [4:0] b, input logic [15:0] a, input int n,
		input logic [31:0] d);
		logic [15:0] ak;
		chk("write count", n, wlog.size());
		for (int k = 0; k < n && k < wlog.size(); k++) begin
			ak = a + 16'(k);
			chk("write entry", {3'h0, b, ak, d[31 - 8 * k -: 8]}, {3'h0, wlog[k]});
		end
	endtask

	initial begin
		miscompares = 0;
		num_checks = 0;
		rst = 1'h1;
		strap = 4'h0;
		fixed_wiring = 1'h0;
		cmd_valid = 1'h0;
		cmd_write = 1'h0;
		cmd_block = 5'h00;
		cmd_addr = 16'h0000;
		cmd_mode = 2'h0;
		cmd_len = 3'h0;
		cmd_wdata = 32'h0;
		do_reset(4'h0, 1'h0);
		chk("frame active", 32'h0, {31'h0, frame_active});
		xfer(1'h1, 5'h09, 16'hFFFF, 2'h0, 3'h3, 32'hC35A8100);
		chk_writes(5'h09, 16'hFFFF, 3, 32'hC35A8100);
		xfer(1'h0, 5'h03, 16'h12FE, 2'h0, 3'h4, 32'h0);
		chk("read data", rd_exp(16'h12FE, 4), rsp_rdata);
		chk_writes(5'h03, 16'h12FE, 0, 32'h0);
		foreach (blks[j]) begin
			exp_n = (blks[j][1:0] == 2'h0 && blks[j][4:2] != 3'h0) ? 0 : 1;
			xfer(1'h1, blks[j], 16'h0040, 2'h0, 3'h1, 32'h3C000000);
			chk_writes(blks[j], 16'h0040, exp_n, 32'h3C000000);
		end
		xfer(1'h0, 5'h14, 16'h0040, 2'h0, 3'h1, 32'h0);
		chk("reserved read", 32'h0, rsp_rdata);
		// Strap off SPI: the slave stays deaf to a whole frame
		do_reset(4'h2, 1'h0);
		chk("spi enabled", 32'h0, {31'h0, spi_enabled});
		xfer(1'h1, 5'h01, 16'h0001, 2'h0, 3'h1, 32'hFF000000);
		chk("frame active", 32'h0, {31'h0, frame_active});
		chk_writes(5'h01, 16'h0001, 0, 32'hFF000000);
		do_reset(4'h1, 1'h1);
		chk("spi enabled", 32'h1, {31'h0, spi_enabled});
		chk("frame active", 32'h1, {31'h0, frame_active});
		cmd_mode <= 2'h0;
		repeat (2) @(posedge clk);
		chk("ready on mode 00", 32'h0, {31'h0, cmd_ready});
		for (int m = 1; m < 4; m++) begin
			xfer(1'h1, 5'h0A, 16'h0100, m[1:0], 3'h0, 32'h11223344);
			chk_writes(5'h0A, 16'h0100, m == 3 ? 4 : m, 32'h11223344);
			xfer(1'h0, 5'h0A, 16'h0200, m[1:0], 3'h0, 32'h0);
			chk("fixed read", rd_exp(16'h0200, m == 3 ? 4 : m), rsp_rdata);
		end
		test_done;
	end
endmodule
`default_nettype wire
